// ### design/pbwp_top.sv
// Page-bounds write protection between address/data registers and main storage.
// Assumes all inputs come from processor logic on clk_i, so none is synchronised.
module pbwp_top (
  // Clock and reset
  input  wire logic                        clk_i,
  input  wire logic                        resetn_i,
  // Processor address and data registers
  input  wire logic [pbwp_pkg::WORD_W-1:0] addr_i,
  input  wire logic [pbwp_pkg::WORD_W-1:0] wdata_i,
  // Storage request from the sequencer
  input  wire logic                        ms_write_i,
  input  wire pbwp_pkg::pbwp_strobe_t      byte_strobe_i,
  // Time-slice ownership
  input  wire logic [pbwp_pkg::STATE_W-1:0] timeslice_grant_lines_i,
  // Option register accesses
  input  wire logic                        option_access_strobe_i,
  input  wire logic                        write_option_reg_instr_i,
  input  wire logic                        read_option_reg_instr_i,
  input  wire logic                        panel_option_request_i,
  // Storage side
  output logic [pbwp_pkg::PAGE_W-1:0]      page_address_to_storage_o,
  output logic [pbwp_pkg::XADDR_W-1:0]     ext_address_to_storage_o,
  output pbwp_pkg::pbwp_strobe_t           storage_strobe_o,
  output logic [pbwp_pkg::WORD_W-1:0]      storage_wdata_o,
  // Protection status
  output logic                             write_permit_o,
  output logic                             outbound_o,
  output logic                             trap_request_o,
  // Option read data
  output logic [pbwp_pkg::WORD_W-1:0]      option_rdata_o,
  output logic                             option_rvalid_o
);

  pbwp_pkg::pbwp_bounds_t              bounds_r   [pbwp_pkg::NUM_PROT];
  pbwp_pkg::pbwp_bounds_t              bounds_nxt [pbwp_pkg::NUM_PROT];
  logic [pbwp_pkg::STATE_W-1:0]        state_select_lines;
  logic                                state_select_msb;
  logic                                state_select_mid;
  logic                                protected_state;
  logic [1:0]                          sel_idx;
  pbwp_pkg::pbwp_bounds_t              sel_bounds;
  logic [pbwp_pkg::PAGE_W-1:0]         page;
  logic                                in_range;
  logic                                check_active;
  logic                                write_permit;
  logic                                outbound_r;
  logic                                outbound_nxt;
  logic [pbwp_pkg::WORD_W-1:0]         option_rdata_r;
  logic [pbwp_pkg::WORD_W-1:0]         option_rdata_nxt;
  logic                                option_rvalid_r;
  logic                                option_rvalid_nxt;

  // Processor number source: option address bits during an access, grant otherwise
  always_comb begin
    if (option_access_strobe_i) begin
      state_select_lines = addr_i[pbwp_pkg::SEL_LSB +: pbwp_pkg::STATE_W];
    end else begin
      state_select_lines = timeslice_grant_lines_i;
    end
    state_select_msb = state_select_lines[2];
    state_select_mid = state_select_lines[1];
    protected_state  = (state_select_lines >= pbwp_pkg::FIRST_PROT_STATE) &&
                       (state_select_lines <= pbwp_pkg::LAST_PROT_STATE);
    sel_idx          = 2'(state_select_lines - pbwp_pkg::FIRST_PROT_STATE);
  end

  // Selector steering both halves of the chosen register to the compares
  always_comb begin
    // 5 -> entry 0, 6 -> entry 1, 7 -> entry 2; unprotected numbers fall back to entry 0
    sel_bounds = bounds_r[0];
    if (state_select_msb && state_select_mid) begin
      if (state_select_lines[0]) begin
        sel_bounds = bounds_r[2];
      end else begin
        sel_bounds = bounds_r[1];
      end
    end
  end

  // Page number is the address high byte; the byte offset is not compared
  assign page = addr_i[pbwp_pkg::PAGE_LSB +: pbwp_pkg::PAGE_W];

  pbwp_compare u_compare (
    .page_i     (page),
    .bounds_i   (sel_bounds),
    .in_range_o (in_range)
  );

  // Reads, option accesses and unprotected states are never checked
  always_comb begin
    check_active = ms_write_i && !option_access_strobe_i && protected_state;
    write_permit = !check_active || in_range;
  end

  // Bounds register file: option writes load the register picked by address bits
  always_comb begin
    for (int i = 0; i < pbwp_pkg::NUM_PROT; i++) begin
      bounds_nxt[i] = bounds_r[i];
    end
    if (option_access_strobe_i && write_option_reg_instr_i && protected_state) begin
      bounds_nxt[sel_idx] = wdata_i;
    end
  end

  // Outbound is set each cycle unless a failed check without a panel option request clears it
  always_comb begin
    outbound_nxt = 1'b1;
    if (!write_permit && !panel_option_request_i) begin
      outbound_nxt = 1'b0;
    end
  end

  // Read data is registered; unprotected numbers read as zero
  always_comb begin
    option_rvalid_nxt = option_access_strobe_i && read_option_reg_instr_i;
    option_rdata_nxt  = option_rdata_r;
    if (option_rvalid_nxt) begin
      option_rdata_nxt = protected_state ? sel_bounds : 16'h0000;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < pbwp_pkg::NUM_PROT; i++) begin
        bounds_r[i] <= '{upper: pbwp_pkg::UPPER_RST, lower: pbwp_pkg::LOWER_RST};
      end
      outbound_r      <= 1'b1;
      option_rdata_r  <= 16'h0000;
      option_rvalid_r <= 1'b0;
    end else begin
      for (int i = 0; i < pbwp_pkg::NUM_PROT; i++) begin
        bounds_r[i] <= bounds_nxt[i];
      end
      outbound_r      <= outbound_nxt;
      option_rdata_r  <= option_rdata_nxt;
      option_rvalid_r <= option_rvalid_nxt;
    end
  end

  // Strobes are gated combinationally so the abort lands in the same write cycle;
  // a registered outbound alone would let the offending write through.
  always_comb begin
    storage_strobe_o.upper = byte_strobe_i.upper && !option_access_strobe_i && write_permit;
    storage_strobe_o.lower = byte_strobe_i.lower && !option_access_strobe_i && write_permit;
    trap_request_o         = !write_permit && !panel_option_request_i;
  end

  // Only 64 KiB of storage is addressed, so the extension stays grounded
  assign ext_address_to_storage_o  = pbwp_pkg::XADDR_ZERO;
  assign page_address_to_storage_o = page;
  assign storage_wdata_o           = wdata_i;
  assign write_permit_o            = write_permit;
  assign outbound_o                = outbound_r;
  assign option_rdata_o            = option_rdata_r;
  assign option_rvalid_o           = option_rvalid_r;

endmodule

// ### design/pbwp_pkg.sv
// Shared constants and carriers for the page-bounds write protection block.
// Assumes a single 50 MHz processor clock and synchronous active-low reset.
package pbwp_pkg;

  // Bit numbering is big-endian: documented bit 00 is the MSB of a 16-bit word
  localparam int unsigned WORD_W       = 16;
  localparam int unsigned PAGE_W       = 8;
  localparam int unsigned STATE_W      = 3;
  localparam int unsigned XADDR_W      = 4;
  localparam int unsigned PAGE_BYTES   = 256;
  localparam int unsigned MAX_MS_BYTES = 65536;

  // Upper limit field occupies doc bits 00-07, lower limit doc bits 08-15
  localparam int unsigned UPPER_LSB = 8;
  localparam int unsigned LOWER_LSB = 0;
  // Page number is address bits 0-7, the high byte of the 16-bit address
  localparam int unsigned PAGE_LSB  = 8;
  // Processor number in address bits 8,9,10 (bit 8 is the msb of the number)
  localparam int unsigned SEL_LSB   = 5;

  localparam logic [PAGE_W-1:0]  UPPER_RST = 8'hFF;
  localparam logic [PAGE_W-1:0]  LOWER_RST = 8'h00;
  localparam logic [STATE_W-1:0] FIRST_PROT_STATE = 3'h5;
  localparam logic [STATE_W-1:0] LAST_PROT_STATE  = 3'h7;
  localparam int unsigned        NUM_PROT = 3;
  localparam logic [XADDR_W-1:0] XADDR_ZERO = 4'h0;

  typedef struct packed {
    logic [PAGE_W-1:0] upper;
    logic [PAGE_W-1:0] lower;
  } pbwp_bounds_t;

  typedef struct packed {
    logic upper;
    logic lower;
  } pbwp_strobe_t;

endpackage

// ### design/pbwp_compare.sv
// Dual limit compare network for one selected bounds register.
// Assumes page and bounds come from logic on the same clock.
module pbwp_compare (
  // Operands
  input  wire logic                 [pbwp_pkg::PAGE_W-1:0] page_i,
  input  wire pbwp_pkg::pbwp_bounds_t                      bounds_i,
  // Results
  output logic                                             in_range_o
);

  logic upper_ok;
  logic lower_ok;

  always_comb begin
    upper_ok   = (page_i <= bounds_i.upper);
    lower_ok   = (page_i >= bounds_i.lower);
    // Equal limits leave exactly one page; FF/00 passes every page
    in_range_o = upper_ok & lower_ok;
  end

endmodule

// ### tb/pbwp_props.sv
// Port assertions for the page-bounds write protection block.
// Bound into pbwp_top; one clock, synchronous active-low reset.
module pbwp_props (
  // Clock and reset
  input wire logic                   clk_i,
  input wire logic                   resetn_i,
  // Requests
  input wire logic [15:0]            addr_i,
  input wire logic                   ms_write_i,
  input wire pbwp_pkg::pbwp_strobe_t byte_strobe_i,
  input wire logic [2:0]             timeslice_grant_lines_i,
  input wire logic                   option_access_strobe_i,
  input wire logic                   read_option_reg_instr_i,
  input wire logic                   panel_option_request_i,
  // Results
  input wire logic [7:0]             page_address_to_storage_o,
  input wire logic [3:0]             ext_address_to_storage_o,
  input wire pbwp_pkg::pbwp_strobe_t storage_strobe_o,
  input wire logic                   write_permit_o,
  input wire logic                   outbound_o,
  input wire logic                   trap_request_o,
  input wire logic                   option_rvalid_o
);
  timeunit 1ns;
  timeprecision 1ns;
  wire logic checked;
  wire logic rd_req;
  assign checked = ms_write_i && timeslice_grant_lines_i >= 3'h5 && !option_access_strobe_i;
  assign rd_req = option_access_strobe_i && read_option_reg_instr_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  a_page_fwd: assert property (page_address_to_storage_o == addr_i[15:8])
    else $error("page number not forwarded");
  a_ext_zero: assert property (ext_address_to_storage_o == 4'h0)
    else $error("extended address not zero");
  a_unchecked_ok: assert property (!checked |-> write_permit_o)
    else $error("unchecked access refused");
  a_fail_kills: assert property (!write_permit_o || option_access_strobe_i |-> storage_strobe_o == 2'h0)
    else $error("write strobe not suppressed");
  a_pass_strobe: assert property (write_permit_o && !option_access_strobe_i |-> storage_strobe_o == byte_strobe_i)
    else $error("permitted strobe altered");
  a_trap_cause: assert property (trap_request_o == (!write_permit_o && !panel_option_request_i))
    else $error("trap request wrong");
  a_outbound_clr: assert property (trap_request_o |=> !outbound_o)
    else $error("outbound not cleared");
  a_outbound_set: assert property (!trap_request_o |=> outbound_o)
    else $error("outbound not restored");
  a_read_answer: assert property (rd_req && addr_i[7:5] >= 3'h5 |=> option_rvalid_o)
    else $error("read not answered");
  a_rvalid_cause: assert property (option_rvalid_o |-> $past(rd_req))
    else $error("read valid without request");
  c_trap: cover property (trap_request_o);
  c_read: cover property (option_rvalid_o);
  c_panel: cover property (!write_permit_o && panel_option_request_i);
endmodule

bind pbwp_top pbwp_props u_props (.clk_i, .resetn_i, .addr_i, .ms_write_i, .byte_strobe_i,
  .timeslice_grant_lines_i, .option_access_strobe_i, .read_option_reg_instr_i, .panel_option_request_i,
  .page_address_to_storage_o, .ext_address_to_storage_o, .storage_strobe_o, .write_permit_o,
  .outbound_o, .trap_request_o, .option_rvalid_o);

// ### tb/pbwp_store_model.sv
// Main storage write path model: counts accepted writes and keeps the last data word.
// Assumes strobes and data come straight from pbwp_top on clk_i.
module pbwp_store_model (
  input  wire logic                   clk_i,
  input  wire pbwp_pkg::pbwp_strobe_t strobe_i,
  input  wire logic [15:0]            data_i,
  output int                          count_o,
  output logic [15:0]                 last_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial count_o = 0;
  initial last_o = 16'h0000;
  // Any byte strobe commits the data word to storage
  always @(posedge clk_i) begin
    if (strobe_i != 2'h0) begin
      count_o <= count_o + 1;
      last_o <= data_i;
    end
  end
endmodule

// ### tb/page_bounds_write_protect_tb.sv
// Self-checking bench for pbwp_top acting as the microcode sequencer.
// Assumes the storage model and bound checker are compiled before it.
module page_bounds_write_protect_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 0, resetn_i = 0, ms_write_i = 0, option_access_strobe_i = 0;
  logic write_option_reg_instr_i = 0, read_option_reg_instr_i = 0, panel_option_request_i = 0;
  logic [15:0] addr_i = 16'h0000, wdata_i = 16'h0000, option_rdata_o, storage_wdata_o, last;
  logic [2:0] timeslice_grant_lines_i = 3'h0;
  logic [7:0] page_address_to_storage_o;
  logic [3:0] ext_address_to_storage_o;
  logic write_permit_o, outbound_o, trap_request_o, option_rvalid_o;
  pbwp_pkg::pbwp_strobe_t byte_strobe_i = 2'h0, storage_strobe_o;
  int err_total = 0, check_count = 0, wr_cnt;
  pbwp_top dut (.clk_i, .resetn_i, .addr_i, .wdata_i, .ms_write_i, .byte_strobe_i,
    .timeslice_grant_lines_i, .option_access_strobe_i, .write_option_reg_instr_i,
    .read_option_reg_instr_i, .panel_option_request_i, .page_address_to_storage_o,
    .ext_address_to_storage_o, .storage_strobe_o, .storage_wdata_o, .write_permit_o,
    .outbound_o, .trap_request_o, .option_rdata_o, .option_rvalid_o);
  pbwp_store_model store (.clk_i, .strobe_i(storage_strobe_o), .data_i(storage_wdata_o),
    .count_o(wr_cnt), .last_o(last));
  always #10 clk_i = ~clk_i;
  task cmp(input string nm, input logic [15:0] e, g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task stop_test;
    $display("mismatches %0d checks %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Option accesses use high address byte 1E/1F, as base registers would
  task wr_bnd(input logic [2:0] s, input logic [15:0] v);
    @(posedge clk_i);
    option_access_strobe_i <= 1; write_option_reg_instr_i <= 1; byte_strobe_i <= 2'h3;
    addr_i <= {8'h1E, s, 5'h00}; wdata_i <= v;
    #5 cmp("opt_strobe", 16'h0, storage_strobe_o);
    @(posedge clk_i);
    option_access_strobe_i <= 0; write_option_reg_instr_i <= 0; byte_strobe_i <= 2'h0;
  endtask
  task rd_bnd(input logic [2:0] s, input logic [15:0] e);
    @(posedge clk_i);
    option_access_strobe_i <= 1; read_option_reg_instr_i <= 1; addr_i <= {8'h1F, s, 5'h00};
    @(posedge clk_i);
    option_access_strobe_i <= 0; read_option_reg_instr_i <= 0;
    #5 cmp("rvalid", 16'h1, {15'h0, option_rvalid_o});
    cmp("rdata", e, option_rdata_o);
  endtask
  task chk(input logic [2:0] g, input logic [7:0] pg, input logic w, p, ok);
    int n;
    n = wr_cnt;
    @(posedge clk_i);
    timeslice_grant_lines_i <= g; addr_i <= {pg, 8'h5A}; wdata_i <= {pg, 8'hC3};
    ms_write_i <= w; panel_option_request_i <= p; byte_strobe_i <= 2'h3;
    #5 cmp("permit", {15'h0, ok}, {15'h0, write_permit_o});
    cmp("strobe", ok ? 16'h3 : 16'h0, {14'h0, storage_strobe_o});
    cmp("trap", {15'h0, !ok & !p}, {15'h0, trap_request_o});
    cmp("page", {8'h0, pg}, {8'h0, page_address_to_storage_o});
    @(posedge clk_i);
    ms_write_i <= 0; panel_option_request_i <= 0; byte_strobe_i <= 2'h0;
    #5 cmp("outbound", {15'h0, ok | p}, {15'h0, outbound_o});
    cmp("stored", 16'(n + ok), 16'(wr_cnt));
    if (ok) cmp("data", {pg, 8'hC3}, last);
  endtask
  task t_reset;
    for (int s = 5; s < 8; s++) rd_bnd(3'(s), 16'hFF00);
  endtask
  task t_range;
    wr_bnd(3'h6, 16'h3020);
    rd_bnd(3'h6, 16'h3020);
    chk(3'h6, 8'h1F, 1, 0, 0);
    chk(3'h6, 8'h20, 1, 0, 1);
    chk(3'h6, 8'h30, 1, 0, 1);
    chk(3'h6, 8'h31, 1, 0, 0);
    chk(3'h5, 8'h31, 1, 0, 1);
  endtask
  task t_equal;
    wr_bnd(3'h7, 16'h4444);
    chk(3'h7, 8'h43, 1, 0, 0);
    chk(3'h7, 8'h44, 1, 0, 1);
    chk(3'h7, 8'h45, 1, 0, 0);
  endtask
  task t_other;
    chk(3'h4, 8'h99, 1, 0, 1);
    chk(3'h6, 8'h99, 0, 0, 1);
    wr_bnd(3'h3, 16'h1234);
    rd_bnd(3'h3, 16'h0000);
    rd_bnd(3'h6, 16'h3020);
    chk(3'h6, 8'h99, 1, 1, 0);
  endtask
  initial begin
    #100000;
    err_total++;
    stop_test;
  end
  initial begin
    repeat (3) @(posedge clk_i);
    resetn_i <= 1;
    t_reset;
    t_range;
    t_equal;
    t_other;
    stop_test;
  end
endmodule
